// file: verilog/rtcbcd_calendar.sv
`timescale 1ns/1ps
`include "rtcbcd_regs.svh"

// Operation
// - integrity flag bit 7, starts set
// - seconds BCD, tens 6:4, units 3:0
// - minutes BCD, tens 6:4, bit 7 unused
// - hours BCD, tens 5:4, bits 7:6 unused
// - day BCD, tens 5:4, top bits unused
// - leap February when year divisible by four
// - weekday 0 to 6 in bits 2:0
// - month BCD 01 to 12, tens bit 4
// - century bit toggles on year wrap
// - century defaults zero, freely writable
// - years two BCD digits 00 to 99
// - hold increments during access, apply afterwards
// - time bits keep contents across reset
module rtcbcd_calendar #(
  parameter int XTAL_HZ = `RTCBCD_XTAL_HZ
) (
  // clocks and reset
  input  wire logic       ref_clk_i,
  input  wire logic       srst_i,
  input  wire logic       xtal_clk_i,
  input  wire logic       xtal_rst_i,
  // register port
  input  wire logic       acc_active_i,
  input  wire logic       wr_en_i,
  input  wire logic [7:0] addr_i,
  input  wire logic [7:0] wdata_i,
  // read data
  output logic      [7:0] rdata_o,
  output logic            pending_o
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic       integ;
  logic [6:0] sec;
  logic [6:0] mins;
  logic [5:0] hrs;
  logic [5:0] dom;
  logic [2:0] dow;
  logic [4:0] mon;
  logic       cent;
  logic [7:0] yr;

  logic       tick_tgl;
  logic [2:0] tgl_sync;
  logic       tick_pulse;
  logic       pend;
  logic       do_inc;
  rtcbcd_pkg::rtcbcd_acc_e acc_st;

  // ----------------------------------------------------------------
  // second tick crossing
  // ----------------------------------------------------------------
  rtcbcd_tick_gen #(
    .XTAL_HZ (XTAL_HZ)
  ) u_tick (
    .xtal_clk_i (xtal_clk_i),
    .xtal_rst_i (xtal_rst_i),
    .tick_tgl_o (tick_tgl)
  );

  // no reset: filling with the toggle level avoids a false edge after reset
  always_ff @(posedge ref_clk_i) begin
    tgl_sync <= {tgl_sync[1:0], tick_tgl};
  end

  assign tick_pulse = tgl_sync[2] ^ tgl_sync[1];

  // ----------------------------------------------------------------
  // access hold-off
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      acc_st <= rtcbcd_pkg::RTCBCD_IDLE;
    end else begin
      case (acc_st)
        rtcbcd_pkg::RTCBCD_IDLE:  if (acc_active_i) acc_st <= rtcbcd_pkg::RTCBCD_BUSY;
        rtcbcd_pkg::RTCBCD_BUSY:  if (!acc_active_i) acc_st <= rtcbcd_pkg::RTCBCD_FLUSH;
        rtcbcd_pkg::RTCBCD_FLUSH: acc_st <= rtcbcd_pkg::RTCBCD_IDLE;
        default:                  acc_st <= rtcbcd_pkg::RTCBCD_IDLE;
      endcase
    end
  end

  // held tick is applied once access ends
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      pend <= 1'b0;
    end else if (tick_pulse && acc_active_i) begin
      pend <= 1'b1;
    end else if (do_inc) begin
      pend <= tick_pulse;
    end
  end

  assign do_inc = !acc_active_i && (pend || tick_pulse);

  // ----------------------------------------------------------------
  // carry chain helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    if (v[3:0] == 4'h9) begin
      bcd_inc = {v[7:4] + 4'h1, 4'h0};
    end else begin
      bcd_inc = {v[7:4], v[3:0] + 4'h1};
    end
  endfunction

  logic       yr_leap;
  logic [5:0] last_day;
  logic       sec_wrap;
  logic       min_wrap;
  logic       hr_wrap;
  logic       dom_wrap;
  logic       mon_wrap;
  logic       yr_wrap;
  logic [7:0] sec_up, min_up, hr_up, dom_up, mon_up;

  // divisible by 4: units parity with tens parity
  assign yr_leap = (yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
                          : (yr[3:0] == 4'h0 || yr[3:0] == 4'h4
                             || yr[3:0] == 4'h8));

  always_comb begin
    case (mon)
      5'h02:   last_day = yr_leap ? 6'h29 : 6'h28;
      5'h04, 5'h06, 5'h09, 5'h11: last_day = 6'h30;
      default: last_day = 6'h31;
    endcase
  end

  assign sec_wrap = (sec == 7'h59);
  assign min_wrap = sec_wrap && (mins == 7'h59);
  assign hr_wrap  = min_wrap && (hrs == 6'h23);
  assign dom_wrap = hr_wrap && (dom == last_day);
  assign mon_wrap = dom_wrap && (mon == 5'h12);
  assign yr_wrap  = mon_wrap && (yr == 8'h99);

  assign sec_up = bcd_inc({1'b0, sec});
  assign min_up = bcd_inc({1'b0, mins});
  assign hr_up  = bcd_inc({2'b00, hrs});
  assign dom_up = bcd_inc({2'b00, dom});
  assign mon_up = bcd_inc({3'b000, mon});

  logic wr_hit;
  assign wr_hit = wr_en_i && acc_active_i;

  // ----------------------------------------------------------------
  // integrity flag
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      integ <= `RTCBCD_INTEG_RST;
    end else if (wr_hit && addr_i == `RTCBCD_OFS_SECONDS) begin
      integ <= wdata_i[`RTCBCD_INTEG_BIT];
    end
  end

  // ----------------------------------------------------------------
  // time counters; only century has a reset, the rest survive it
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (wr_hit && addr_i == `RTCBCD_OFS_SECONDS) begin
      sec <= wdata_i[6:0];
    end else if (do_inc) begin
      sec <= sec_wrap ? 7'h00 : sec_up[6:0];
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (wr_hit && addr_i == `RTCBCD_OFS_MINUTES) begin
      mins <= wdata_i[6:0];
    end else if (do_inc && sec_wrap) begin
      mins <= min_wrap ? 7'h00 : min_up[6:0];
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (wr_hit && addr_i == `RTCBCD_OFS_HOURS) begin
      hrs <= wdata_i[5:0];
    end else if (do_inc && min_wrap) begin
      hrs <= hr_wrap ? 6'h00 : hr_up[5:0];
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (wr_hit && addr_i == `RTCBCD_OFS_DOM) begin
      dom <= wdata_i[5:0];
    end else if (do_inc && hr_wrap) begin
      dom <= dom_wrap ? 6'h01 : dom_up[5:0];
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (wr_hit && addr_i == `RTCBCD_OFS_DOW) begin
      dow <= wdata_i[2:0];
    end else if (do_inc && hr_wrap) begin
      dow <= (dow >= 3'h6) ? 3'h0 : dow + 3'h1;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (wr_hit && addr_i == `RTCBCD_OFS_MONTH) begin
      mon <= wdata_i[4:0];
    end else if (do_inc && dom_wrap) begin
      mon <= mon_wrap ? 5'h01 : mon_up[4:0];
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      cent <= `RTCBCD_CENTURY_RST;
    end else if (wr_hit && addr_i == `RTCBCD_OFS_MONTH) begin
      cent <= wdata_i[`RTCBCD_CENTURY_BIT];
    end else if (do_inc && yr_wrap) begin
      cent <= ~cent;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (wr_hit && addr_i == `RTCBCD_OFS_YEAR) begin
      yr <= wdata_i;
    end else if (do_inc && mon_wrap) begin
      yr <= yr_wrap ? 8'h00 : bcd_inc(yr);
    end
  end

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      rdata_o <= 8'h00;
    end else begin
      case (addr_i)
        `RTCBCD_OFS_SECONDS: rdata_o <= {integ, sec};
        `RTCBCD_OFS_MINUTES: rdata_o <= {1'b0, mins};
        `RTCBCD_OFS_HOURS:   rdata_o <= {2'b00, hrs};
        `RTCBCD_OFS_DOM:     rdata_o <= {2'b00, dom};
        `RTCBCD_OFS_DOW:     rdata_o <= {5'h00, dow};
        `RTCBCD_OFS_MONTH:   rdata_o <= {cent, 2'b00, mon};
        `RTCBCD_OFS_YEAR:    rdata_o <= yr;
        default:             rdata_o <= 8'h00;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      pending_o <= 1'b0;
    end else begin
      pending_o <= pend;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_tick_in_access;
    tick_pulse && acc_active_i;
  endsequence

  property p_hold_off;
    @(posedge ref_clk_i) disable iff (srst_i)
      acc_active_i && !wr_hit |=> $stable(sec);
  endproperty
  a_hold_off: assert property (p_hold_off) else $error("seconds moved in access");

  property p_pend_set;
    @(posedge ref_clk_i) disable iff (srst_i)
      s_tick_in_access |=> pend;
  endproperty
  a_pend_set: assert property (p_pend_set) else $error("tick in access not held");

  property p_pend_applied;
    @(posedge ref_clk_i) disable iff (srst_i)
      acc_st == rtcbcd_pkg::RTCBCD_BUSY && !acc_active_i && pend |=> sec != $past(sec);
  endproperty
  a_pend_applied: assert property (p_pend_applied) else $error("held tick lost");

  property p_integ_reset;
    @(posedge ref_clk_i) srst_i |=> integ;
  endproperty
  a_integ_reset: assert property (p_integ_reset) else $error("integrity not set");

  property p_sec_wrap;
    @(posedge ref_clk_i) disable iff (srst_i)
      do_inc && sec == 7'h59 && !wr_hit |=> sec == 7'h00;
  endproperty
  a_sec_wrap: assert property (p_sec_wrap) else $error("seconds no wrap");

  property p_min_carry;
    @(posedge ref_clk_i) disable iff (srst_i)
      do_inc && sec_wrap && mins == 7'h09 && !wr_hit |=> mins == 7'h10;
  endproperty
  a_min_carry: assert property (p_min_carry) else $error("minute carry bad");

  property p_hr_wrap;
    @(posedge ref_clk_i) disable iff (srst_i)
      do_inc && hr_wrap && !wr_hit |=> hrs == 6'h00;
  endproperty
  a_hr_wrap: assert property (p_hr_wrap) else $error("hours no wrap");

  property p_leap;
    @(posedge ref_clk_i) disable iff (srst_i)
      do_inc && hr_wrap && mon == 5'h02 && dom == 6'h28 && yr == 8'h00 && !wr_hit
      |=> dom == 6'h29;
  endproperty
  a_leap: assert property (p_leap) else $error("leap day skipped");

  property p_day_wrap;
    @(posedge ref_clk_i) disable iff (srst_i)
      do_inc && hr_wrap && mon == 5'h04 && dom == 6'h30 && !wr_hit |=> dom == 6'h01;
  endproperty
  a_day_wrap: assert property (p_day_wrap) else $error("april wrap bad");

  property p_century;
    @(posedge ref_clk_i) disable iff (srst_i)
      do_inc && yr_wrap && !wr_hit |=> cent != $past(cent) && yr == 8'h00;
  endproperty
  a_century: assert property (p_century) else $error("century no toggle");

  property p_dow_wrap;
    @(posedge ref_clk_i) disable iff (srst_i)
      do_inc && hr_wrap && dow == 3'h6 && !wr_hit |=> dow == 3'h0;
  endproperty
  a_dow_wrap: assert property (p_dow_wrap) else $error("weekday no wrap");

endmodule

// file: verilog/rtcbcd_regs.svh
`ifndef RTCBCD_REGS_SVH
`define RTCBCD_REGS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define RTCBCD_OFS_SECONDS   8'h02
`define RTCBCD_OFS_MINUTES   8'h03
`define RTCBCD_OFS_HOURS     8'h04
`define RTCBCD_OFS_DOM       8'h05
`define RTCBCD_OFS_DOW       8'h06
`define RTCBCD_OFS_MONTH     8'h07
`define RTCBCD_OFS_YEAR      8'h08

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define RTCBCD_INTEG_BIT     7
`define RTCBCD_CENTURY_BIT   7

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RTCBCD_INTEG_RST     1'h1
`define RTCBCD_CENTURY_RST   1'h0

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define RTCBCD_XTAL_HZ       32768

`endif

// file: verilog/rtcbcd_pkg.sv
package rtcbcd_pkg;

  typedef logic [7:0] rtcbcd_byte_t;

  // main-domain access state
  typedef enum logic [1:0] {
    RTCBCD_IDLE = 2'b00,
    RTCBCD_BUSY = 2'b01,
    RTCBCD_FLUSH = 2'b11
  } rtcbcd_acc_e;

endpackage

// file: verilog/rtcbcd_tick_gen.sv
`timescale 1ns/1ps
`include "rtcbcd_regs.svh"

// ----------------------------------------------------------------
// 1 Hz tick on the crystal clock, handed over as a toggle
// ----------------------------------------------------------------
module rtcbcd_tick_gen #(
  parameter int XTAL_HZ = `RTCBCD_XTAL_HZ
) (
  // crystal domain
  input  wire logic xtal_clk_i,
  input  wire logic xtal_rst_i,
  // toggle per second
  output logic      tick_tgl_o
);

  localparam int CW = $clog2(XTAL_HZ);

  logic [CW-1:0] div_cnt;

  always_ff @(posedge xtal_clk_i) begin
    if (xtal_rst_i) begin
      div_cnt    <= '0;
      tick_tgl_o <= 1'b0;
    end else if (div_cnt == CW'(XTAL_HZ - 1)) begin
      div_cnt    <= '0;
      tick_tgl_o <= ~tick_tgl_o;
    end else begin
      div_cnt <= div_cnt + 1'b1;
    end
  end

endmodule

// file: bench/rtcbcd_host_model.sv
`timescale 1ns/1ps
`include "rtcbcd_regs.svh"

// ----------------------------------------------------------------
// host side of the register port
// ----------------------------------------------------------------
module rtcbcd_host_model (
  // clock
  input  wire logic       ref_clk_i,
  // register port
  output logic            acc_active_o,
  output logic            wr_en_o,
  output logic      [7:0] addr_o,
  output logic      [7:0] wdata_o,
  input  wire logic [7:0] rdata_i
);
  initial begin
    acc_active_o = 1'b0;
    wr_en_o      = 1'b0;
    addr_o       = 8'h00;
    wdata_o      = 8'h00;
  end

  task automatic end_acc();
    @(negedge ref_clk_i);
    acc_active_o = 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk_i);
    wr_en_o = 1'b1;
    addr_o  = a;
    wdata_o = d;
    @(negedge ref_clk_i);
    wr_en_o = 1'b0;
    // released data no longer shows the last byte
    wdata_o = ~d;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge ref_clk_i);
    addr_o = a;
    @(negedge ref_clk_i);
    d = rdata_i;
  endtask

  // ----------------------------------------------------------------
  // seconds through years in one access, left open
  // ----------------------------------------------------------------
  task automatic write_burst(input logic [7:0] img [7]);
    @(negedge ref_clk_i);
    acc_active_o = 1'b1;
    for (int i = 0; i < 7; i++) begin
      wr(`RTCBCD_OFS_SECONDS + 8'(i), img[i]);
    end
  endtask

  task automatic read_burst(output logic [7:0] img [7]);
    @(negedge ref_clk_i);
    acc_active_o = 1'b1;
    for (int i = 0; i < 7; i++) begin
      rd(`RTCBCD_OFS_SECONDS + 8'(i), img[i]);
    end
  endtask
endmodule

// file: bench/rtc_bcd_calendar_registers_test.sv
`timescale 1ns/1ps
`include "rtcbcd_regs.svh"

module rtc_bcd_calendar_registers_test;
  localparam logic [7:0] USED [7] = '{8'hFF, 8'h7F, 8'h3F, 8'h3F, 8'h07, 8'h9F, 8'hFF};
  logic       ref_clk_i, srst_i, xtal_clk_i, xtal_rst_i, acc, wr_en, pending;
  logic [7:0] addr, wdata, rdata;
  logic [7:0] wimg [7];
  logic [7:0] rimg [7];
  int         t [8];
  int         fails = 0;
  int         total_checks = 0;
  int         corner [7][8] = '{'{59, 59, 23, 28, 6, 2, 4, 0}, '{59, 59, 23, 28, 3, 2, 1, 0},
                                '{59, 59, 23, 29, 5, 2, 0, 1}, '{59, 59, 23, 31, 6, 12, 99, 0},
                                '{59, 59, 23, 30, 2, 4, 5, 1}, '{59, 59, 23, 28, 0, 2, 0, 0},
                                '{59, 9, 10, 15, 3, 7, 21, 0}};

  rtcbcd_calendar #(.XTAL_HZ(64)) rtcbcd_calendar_inst (
    .ref_clk_i(ref_clk_i), .srst_i(srst_i), .xtal_clk_i(xtal_clk_i), .xtal_rst_i(xtal_rst_i),
    .acc_active_i(acc), .wr_en_i(wr_en), .addr_i(addr), .wdata_i(wdata),
    .rdata_o(rdata), .pending_o(pending));
  rtcbcd_host_model rtcbcd_host_model_inst (
    .ref_clk_i(ref_clk_i), .acc_active_o(acc), .wr_en_o(wr_en), .addr_o(addr),
    .wdata_o(wdata), .rdata_i(rdata));

  initial ref_clk_i = 1'b0;
  always #12.5 ref_clk_i = ~ref_clk_i;
  initial xtal_clk_i = 1'b0;
  always #32 xtal_clk_i = ~xtal_clk_i;

  // ----------------------------------------------------------------
  // expected calendar
  // ----------------------------------------------------------------
  function automatic int dim(int mo, int y);
    if (mo == 2) return (y % 4 == 0) ? 29 : 28;
    if (mo == 4 || mo == 6 || mo == 9 || mo == 11) return 30;
    return 31;
  endfunction

  function automatic logic [7:0] bcd(int v);
    return 8'((v / 10) * 16 + v % 10);
  endfunction

  function automatic logic [7:0] img(int i);
    if (i == 5) return bcd(t[5]) | ((t[7] == 1) ? 8'h80 : 8'h00);
    return bcd(t[i]);
  endfunction

  function automatic void step();
    t[0]++;
    if (t[0] < 60) return;
    t[0] = 0;
    t[1]++;
    if (t[1] < 60) return;
    t[1] = 0;
    t[2]++;
    if (t[2] < 24) return;
    t[2] = 0;
    t[4] = (t[4] + 1) % 7;
    t[3]++;
    if (t[3] <= dim(t[5], t[6])) return;
    t[3] = 1;
    t[5]++;
    if (t[5] < 13) return;
    t[5] = 1;
    t[6] = (t[6] + 1) % 100;
    if (t[6] == 0) t[7] = 1 - t[7];
  endfunction

  task automatic chk(string name, logic [7:0] exp, logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic wait_pend();
    int n;
    n = 0;
    while (pending !== 1'b1 && n < 400) begin
      @(negedge ref_clk_i);
      n++;
    end
    chk("pending", 8'h01, {7'h00, pending});
  endtask

  // ----------------------------------------------------------------
  // write a time, let one second pass, read it back
  // ----------------------------------------------------------------
  task automatic run_tick(input bit hold);
    for (int i = 0; i < 7; i++) begin
      wimg[i] = img(i) | (8'($urandom) & ~USED[i]);
    end
    rtcbcd_host_model_inst.write_burst(wimg);
    wait_pend();
    rtcbcd_host_model_inst.end_acc();
    step();
    rtcbcd_host_model_inst.read_burst(rimg);
    for (int i = 0; i < 7; i++) begin
      chk("time register", img(i), rimg[i]);
    end
    if (hold) begin
      wait_pend();
      rtcbcd_host_model_inst.rd(`RTCBCD_OFS_SECONDS, rimg[0]);
      chk("held seconds", img(0), rimg[0]);
    end
    rtcbcd_host_model_inst.end_acc();
  endtask

  initial begin
    srst_i = 1'b1;
    xtal_rst_i = 1'b1;
    void'($urandom(17));
    repeat (12) @(negedge ref_clk_i);
    srst_i = 1'b0;
    xtal_rst_i = 1'b0;
    rtcbcd_host_model_inst.read_burst(rimg);
    chk("integrity after reset", 8'h80, rimg[0] & 8'h80);
    chk("century after reset", 8'h00, rimg[5] & 8'h80);
    rtcbcd_host_model_inst.rd(8'h09, rimg[6]);
    chk("unmapped read", 8'h00, rimg[6]);
    rtcbcd_host_model_inst.end_acc();
    for (int k = 0; k < 13; k++) begin
      if (k < 7) begin
        t = corner[k];
      end else begin
        t[5] = 1 + $urandom % 12;
        t[6] = $urandom % 100;
        t[3] = 1 + $urandom % dim(t[5], t[6]);
        t[0] = $urandom % 60;
        t[1] = $urandom % 60;
        t[2] = $urandom % 24;
        t[4] = $urandom % 7;
        t[7] = $urandom % 2;
      end
      run_tick(k == 0);
    end
    // mid-run reset keeps time, flags integrity, clears century
    @(negedge ref_clk_i);
    srst_i = 1'b1;
    repeat (2) @(negedge ref_clk_i);
    srst_i = 1'b0;
    t[7] = 0;
    rtcbcd_host_model_inst.read_burst(rimg);
    for (int i = 0; i < 7; i++) begin
      chk("time after reset", img(i) | ((i == 0) ? 8'h80 : 8'h00), rimg[i]);
    end
    rtcbcd_host_model_inst.end_acc();
    tally_and_finish();
  end

  initial begin
    #500000;
    fails++;
    tally_and_finish();
  end
endmodule
